// file: tcsp_pkg.sv
package tcsp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CMP1_HIGH   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CMP1_LOW    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CMP2_HIGH   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CMP2_LOW    = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CAP1_HIGH   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_CAP1_LOW    = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_CAP2_HIGH   = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_CAP2_LOW    = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH  = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_COUNT_LOW   = 8'h30;

    ////////////////////////////////////////////////////////////////////////////
    // control_reg_one fields
    localparam int C1_OUTPUT_LEVEL_ONE = 0;
    localparam int C1_OUTPUT_LEVEL_TWO = 1;
    localparam int C1_CAPTURE_EDGE_ONE = 2;
    localparam int C1_FORCE_ONE        = 3;
    localparam int C1_FORCE_TWO        = 4;
    localparam int C1_COMPARE_IRQ_EN   = 6;
    localparam int C1_CAPTURE_IRQ_EN   = 7;
    // force bits are strobes and never stored
    localparam logic [7:0] C1_STORE_MASK = 8'hC7;

    // control_reg_two fields
    localparam int C2_PRESCALE_LOW     = 0;
    localparam int C2_PRESCALE_HIGH    = 1;
    localparam int C2_CAPTURE_EDGE_TWO = 2;
    localparam int C2_EXT_EDGE_RISE    = 3;
    localparam int C2_SINGLE_PULSE     = 4;
    localparam int C2_PWM_SELECT       = 5;
    localparam int C2_PIN_ENABLE_TWO   = 6;
    localparam int C2_PIN_ENABLE_ONE   = 7;

    // timer_status_reg fields
    localparam int SR_MATCH_ONE   = 0;
    localparam int SR_MATCH_TWO   = 1;
    localparam int SR_CAPTURE_ONE = 2;
    localparam int SR_CAPTURE_TWO = 3;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset and fixed loads
    localparam logic [15:0] CNT_RESET_VALUE   = 16'hFFFC;
    localparam logic [15:0] CAP_PULSE_VALUE   = 16'hFFFD;
    localparam logic [15:0] CMP_RESET_VALUE   = 16'h8000;
    localparam logic [7:0]  CONTROL_RESET     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // tick source select and divider masks (tick when masked count is all ones)
    localparam logic [1:0] SEL_DIV2 = 2'h0;
    localparam logic [1:0] SEL_DIV4 = 2'h1;
    localparam logic [1:0] SEL_DIV8 = 2'h2;
    localparam logic [1:0] SEL_EXT  = 2'h3;
    localparam logic [2:0] MASK_DIV2 = 3'h1;
    localparam logic [2:0] MASK_DIV4 = 3'h3;
    localparam logic [2:0] MASK_DIV8 = 3'h7;

endpackage

// file: tcsp_tick_if.sv
`timescale 1ns/1ps
interface tcsp_tick_if;
    logic [1:0] prescale_sel;   // tick source select
    logic       ext_edge_rise;  // external clock counts rising edges
    logic       tick;           // one-cycle timer tick

    modport gen  (input prescale_sel, input ext_edge_rise, output tick);
    modport user (output prescale_sel, output ext_edge_rise, input tick);
endinterface

// file: tcsp_tick_gen.sv
`timescale 1ns/1ps
module tcsp_tick_gen
(
    input  wire logic mclk,         // cpu clock
    input  wire logic arst_n,       // async reset, low
    input  wire logic ce,           // clock enable
    input  wire logic ext_clk_pin,  // external timer clock pin
    tcsp_tick_if.gen  tk            // select in, tick out
);
    import tcsp_pkg::*;

    typedef struct packed
    {
        logic [2:0] div;
        logic       s1;
        logic       s2;
        logic       prev;
        logic       tick;
    } tcsp_tg_t;

    tcsp_tg_t q;
    tcsp_tg_t n;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        n      = q;
        n.s1   = ext_clk_pin;
        n.s2   = q.s1;
        n.prev = q.s2;
        n.div  = q.div + 3'h1;
        unique case (tk.prescale_sel)                                  // [R23] [R21]
            SEL_DIV2: n.tick = ((q.div & MASK_DIV2) == MASK_DIV2);
            SEL_DIV4: n.tick = ((q.div & MASK_DIV4) == MASK_DIV4);
            SEL_DIV8: n.tick = ((q.div & MASK_DIV8) == MASK_DIV8);
            SEL_EXT:  n.tick = tk.ext_edge_rise ? (q.s2 & ~q.prev) : (~q.s2 & q.prev);
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            q <= '0;
        else if (ce)
            q <= n;
    end

    assign tk.tick = q.tick;

endmodule // tcsp_tick_gen

// file: tcsp_timer.sv
// What this block does
// R1 - compare both 16-bit compare values with the counter on every tick
// R2 - compare values are software storage only, reset to 8000h
// R3 - a match sets its flag and drives the level on enabled pin
// R4 - compare pin latches are low during reset
// R5 - compare interrupt needs compare enable and clear global mask
// R6 - flag clears by status read while set, then low byte access
// R7 - writing high compare byte stops compares until low byte written
// R8 - software writes high, reads status, then writes low byte
// R9 - pin disabled: no level driven, interrupt still possible
// R10 - flag and level appear in the tick the counter equals value
// R11 - force bit copies level to enabled pin, no flag, no interrupt
// R12 - force bits do nothing in single pulse or pwm mode
// R13 - single pulse select bit enters single pulse mode
// R14 - trigger edge reloads FFFCh, drives level two, sets flag, loads FFFDh
// R15 - trigger raises interrupt when capture interrupt enabled
// R16 - counter reaching compare value one drives level one, ending pulse
// R17 - single pulse never sets match flag one; flag two works
// R18 - pwm and single pulse both set means pwm only
// R19 - single pulse: pin one does no capture, pin two captures
// R20 - single pulse: channel two flags only, drives no pin
// R21 - pulse length is compare value one plus four ticks
// R22 - counter resets to FFFCh, its only reload value
// R23 - both prescale bits set selects external clock pin
// R24 - compare pins hold level until match, trigger or force
// R25 - counter advances one per tick and wraps FFFFh to 0000h
`timescale 1ns/1ps
module tcsp_timer
(
    input  wire logic                        mclk,              // cpu clock
    input  wire logic                        arst_n,            // async reset, low
    input  wire logic                        ce,                // clock enable
    input  wire logic [tcsp_pkg::ADDR_W-1:0] paddr,             // apb address
    input  wire logic                        psel,              // apb select
    input  wire logic                        penable,           // apb enable
    input  wire logic                        pwrite,            // apb direction
    input  wire logic [tcsp_pkg::DATA_W-1:0] pwdata,            // apb write data
    output logic      [tcsp_pkg::DATA_W-1:0] prdata,            // apb read data
    output logic                             pready,            // apb ready
    output logic                             pslverr,           // apb error
    input  wire logic                        irq_mask,          // cpu global mask
    input  wire logic                        ext_clk_pin,       // external clock
    input  wire logic                        capture_pin_one,   // capture input 1
    input  wire logic                        capture_pin_two,   // capture input 2
    output logic                             compare_pin_one,   // compare output 1
    output logic                             compare_pin_two,   // compare output 2
    output logic                             compare_pin_en_one,// pin 1 owned by timer
    output logic                             compare_pin_en_two,// pin 2 owned by timer
    output logic                             timer_irq          // timer interrupt
);
    import tcsp_pkg::*;

    typedef struct packed
    {
        logic [15:0] cnt;
        logic [15:0] cmp1;
        logic [15:0] cmp2;
        logic [15:0] cap1;
        logic [15:0] cap2;
        logic [7:0]  ctl1;
        logic [7:0]  ctl2;
        logic [3:0]  flags;
        logic [3:0]  armed;
        logic [1:0]  cmp_hold;
        logic [1:0]  cap_hold;
        logic        pin1;
        logic        pin2;
        logic        c1_s1;
        logic        c1_s2;
        logic        c1_prev;
        logic        c2_s1;
        logic        c2_s2;
        logic        c2_prev;
        logic        ack;
        logic [7:0]  rdata;
        logic        irq;
    } tcsp_state_t;

    localparam tcsp_state_t STATE_RESET = '{
        cnt:      CNT_RESET_VALUE,
        cmp1:     CMP_RESET_VALUE,
        cmp2:     CMP_RESET_VALUE,
        cap1:     16'h0000,
        cap2:     16'h0000,
        ctl1:     CONTROL_RESET,
        ctl2:     CONTROL_RESET,
        flags:    4'h0,
        armed:    4'h0,
        cmp_hold: 2'h0,
        cap_hold: 2'h0,
        pin1:     1'b0,
        pin2:     1'b0,
        c1_s1:    1'b0,
        c1_s2:    1'b0,
        c1_prev:  1'b0,
        c2_s1:    1'b0,
        c2_s2:    1'b0,
        c2_prev:  1'b0,
        ack:      1'b0,
        rdata:    8'h00,
        irq:      1'b0
    };

    tcsp_state_t q;
    tcsp_state_t n;

    tcsp_tick_if tk ();

    tcsp_tick_gen u_tick
    (
        .mclk        (mclk),
        .arst_n      (arst_n),
        .ce          (ce),
        .ext_clk_pin (ext_clk_pin),
        .tk          (tk)
    );

    assign tk.prescale_sel  = {q.ctl2[C2_PRESCALE_HIGH], q.ctl2[C2_PRESCALE_LOW]};
    assign tk.ext_edge_rise = q.ctl2[C2_EXT_EDGE_RISE];

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CONTROL_ONE, OFS_CONTROL_TWO, OFS_STATUS,
            OFS_CMP1_HIGH, OFS_CMP1_LOW, OFS_CMP2_HIGH, OFS_CMP2_LOW,
            OFS_CAP1_HIGH, OFS_CAP1_LOW, OFS_CAP2_HIGH, OFS_CAP2_LOW,
            OFS_COUNT_HIGH, OFS_COUNT_LOW:
                addr_mapped = 1'b1;
            default:
                addr_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic edge_seen(input logic now, input logic prev,
                                       input logic rise);
        edge_seen = rise ? (now & ~prev) : (~now & prev);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic       pwm_mode;
    logic       pulse_mode;
    logic       access;
    logic       wr;
    logic       rd;
    logic [7:0] wbyte;
    logic       cap1_edge;
    logic       cap2_edge;
    logic       trigger;
    logic       match1;
    logic       match2;
    logic [3:0] set_mask;
    logic [3:0] clr_mask;
    logic       pin_en1;
    logic       pin_en2;

    always_comb
    begin
        n       = q;
        // pwm takes priority over single pulse
        pwm_mode   = q.ctl2[C2_PWM_SELECT]; // [R18]
        pulse_mode = q.ctl2[C2_SINGLE_PULSE] & ~pwm_mode; // [R13]
        pin_en1    = q.ctl2[C2_PIN_ENABLE_ONE];
        pin_en2    = q.ctl2[C2_PIN_ENABLE_TWO];
        access     = psel & penable & q.ack;
        wr         = access & pwrite;
        rd         = access & ~pwrite;
        wbyte      = pwdata[7:0];
        set_mask   = 4'h0;
        clr_mask   = 4'h0;

        // capture pins: two flops, then edge detect on the second
        n.c1_s1   = capture_pin_one;
        n.c1_s2   = q.c1_s1;
        n.c1_prev = q.c1_s2;
        n.c2_s1   = capture_pin_two;
        n.c2_s2   = q.c2_s1;
        n.c2_prev = q.c2_s2;
        cap1_edge = edge_seen(q.c1_s2, q.c1_prev, q.ctl1[C1_CAPTURE_EDGE_ONE]);
        cap2_edge = edge_seen(q.c2_s2, q.c2_prev, q.ctl2[C2_CAPTURE_EDGE_TWO]);
        trigger   = pulse_mode & cap1_edge;

        // counter
        if (tk.tick)
            n.cnt = q.cnt + 16'h0001; // [R25]
        if (trigger)
            n.cnt = CNT_RESET_VALUE; // [R14] [R22]

        // match on the value the counter takes at this tick
        match1 = tk.tick & ~trigger & ~q.cmp_hold[0] & (n.cnt == q.cmp1);   // [R1] [R10]
        match2 = tk.tick & ~trigger & ~q.cmp_hold[1] & (n.cnt == q.cmp2);   // [R1] [R10]

        if (!pwm_mode)
        begin
            if (match1 && !pulse_mode)
                set_mask[SR_MATCH_ONE] = 1'b1; // [R3] [R17]
            if (match2)
                set_mask[SR_MATCH_TWO] = 1'b1; // [R3] [R20]
            // pins hold otherwise; disabled pins get nothing
            if (match1 && pin_en1)
                n.pin1 = q.ctl1[C1_OUTPUT_LEVEL_ONE]; // [R3] [R16] [R9] [R24]
            if (match2 && pin_en2 && !pulse_mode)
                n.pin2 = q.ctl1[C1_OUTPUT_LEVEL_TWO]; // [R3] [R20] [R9]
            if (trigger && pin_en1)
                n.pin1 = q.ctl1[C1_OUTPUT_LEVEL_TWO]; // [R14] [R21]
        end

        // captures
        if (trigger)
        begin
            n.cap1 = CAP_PULSE_VALUE; // [R14]
            set_mask[SR_CAPTURE_ONE] = 1'b1; // [R14] [R15]
        end
        else if (cap1_edge && !pulse_mode && !pwm_mode && !q.cap_hold[0])   // [R19]
        begin
            n.cap1 = q.cnt;
            set_mask[SR_CAPTURE_ONE] = 1'b1;
        end
        if (cap2_edge && !q.cap_hold[1]) // [R19]
        begin
            n.cap2 = q.cnt;
            set_mask[SR_CAPTURE_TWO] = 1'b1;
        end

        // register writes
        if (wr)
        begin
            unique case (paddr)
                OFS_CONTROL_ONE:
                begin
                    n.ctl1 = wbyte & C1_STORE_MASK;
                    // forcing is off in single pulse and pwm
                    if (!pulse_mode && !pwm_mode) // [R12]
                    begin
                        if (wbyte[C1_FORCE_ONE] && pin_en1)
                            n.pin1 = wbyte[C1_OUTPUT_LEVEL_ONE]; // [R11] [R24]
                        if (wbyte[C1_FORCE_TWO] && pin_en2)
                            n.pin2 = wbyte[C1_OUTPUT_LEVEL_TWO]; // [R11]
                    end
                end
                OFS_CONTROL_TWO:
                    n.ctl2 = wbyte;
                OFS_CMP1_HIGH:
                begin
                    n.cmp1[15:8]   = wbyte; // [R2]
                    n.cmp_hold[0]  = 1'b1; // [R7] [R8]
                end
                OFS_CMP1_LOW:
                begin
                    n.cmp1[7:0]    = wbyte; // [R2]
                    n.cmp_hold[0]  = 1'b0; // [R7] [R8]
                end
                OFS_CMP2_HIGH:
                begin
                    n.cmp2[15:8]   = wbyte;
                    n.cmp_hold[1]  = 1'b1; // [R7]
                end
                OFS_CMP2_LOW:
                begin
                    n.cmp2[7:0]    = wbyte;
                    n.cmp_hold[1]  = 1'b0; // [R7]
                end
                default:
                begin
                end
            endcase
        end

        // read side effects: capture high read freezes capture until low read
        if (rd)
        begin
            unique case (paddr)
                OFS_CAP1_HIGH: n.cap_hold[0] = 1'b1;
                OFS_CAP1_LOW:  n.cap_hold[0] = 1'b0;
                OFS_CAP2_HIGH: n.cap_hold[1] = 1'b1;
                OFS_CAP2_LOW:  n.cap_hold[1] = 1'b0;
                default:
                begin
                end
            endcase
        end

        // two-step flag clear: status read arms, low byte access clears
        if (access)
        begin
            unique case (paddr)
                OFS_CMP1_LOW: clr_mask[SR_MATCH_ONE]   = q.armed[SR_MATCH_ONE];   // [R6]
                OFS_CMP2_LOW: clr_mask[SR_MATCH_TWO]   = q.armed[SR_MATCH_TWO];   // [R6]
                OFS_CAP1_LOW: clr_mask[SR_CAPTURE_ONE] = q.armed[SR_CAPTURE_ONE];
                OFS_CAP2_LOW: clr_mask[SR_CAPTURE_TWO] = q.armed[SR_CAPTURE_TWO];
                default:
                begin
                end
            endcase
        end
        n.armed = q.armed & ~clr_mask;
        if (rd && paddr == OFS_STATUS)
            n.armed = n.armed | q.flags; // [R6]
        // a new event in the clearing cycle survives
        n.flags = (q.flags & ~clr_mask) | set_mask; // [R6]

        n.irq = ~irq_mask & // [R5] [R15]
                ((q.ctl1[C1_COMPARE_IRQ_EN] &
                  (n.flags[SR_MATCH_ONE] | n.flags[SR_MATCH_TWO])) |
                 (q.ctl1[C1_CAPTURE_IRQ_EN] &
                  (n.flags[SR_CAPTURE_ONE] | n.flags[SR_CAPTURE_TWO])));

        // apb: one wait state so that read data comes from a flop
        if (psel && penable && !q.ack)
        begin
            n.ack = 1'b1;
            unique case (paddr)
                OFS_CONTROL_ONE: n.rdata = q.ctl1;
                OFS_CONTROL_TWO: n.rdata = q.ctl2;
                OFS_STATUS:      n.rdata = {4'h0, q.flags};
                OFS_CMP1_HIGH:   n.rdata = q.cmp1[15:8];
                OFS_CMP1_LOW:    n.rdata = q.cmp1[7:0];
                OFS_CMP2_HIGH:   n.rdata = q.cmp2[15:8];
                OFS_CMP2_LOW:    n.rdata = q.cmp2[7:0];
                OFS_CAP1_HIGH:   n.rdata = q.cap1[15:8];
                OFS_CAP1_LOW:    n.rdata = q.cap1[7:0];
                OFS_CAP2_HIGH:   n.rdata = q.cap2[15:8];
                OFS_CAP2_LOW:    n.rdata = q.cap2[7:0];
                OFS_COUNT_HIGH:  n.rdata = q.cnt[15:8];
                OFS_COUNT_LOW:   n.rdata = q.cnt[7:0];
                default:         n.rdata = 8'h00;
            endcase
        end
        else if (access)
            n.ack = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            q <= STATE_RESET; // [R2] [R4] [R22]
        else if (ce)
            q <= n;
    end

    assign prdata             = {24'h000000, q.rdata};
    assign pready             = ce & psel & penable & q.ack;
    assign pslverr            = pready & ~addr_mapped(paddr);
    assign compare_pin_one    = q.pin1;
    assign compare_pin_two    = q.pin2;
    assign compare_pin_en_one = q.ctl2[C2_PIN_ENABLE_ONE];
    assign compare_pin_en_two = q.ctl2[C2_PIN_ENABLE_TWO];
    assign timer_irq          = q.irq;

endmodule // tcsp_timer

// file: tcsp_timer_sva.sv
`timescale 1ns/1ps
module tcsp_timer_sva
(
    input wire logic                        mclk,               // clock
    input wire logic                        arst_n,             // reset, low
    input wire logic                        ce,                 // clock enable
    input wire logic [tcsp_pkg::ADDR_W-1:0] paddr,              // apb address
    input wire logic                        psel,               // apb select
    input wire logic                        penable,            // apb enable
    input wire logic                        pwrite,             // apb direction
    input wire logic [tcsp_pkg::DATA_W-1:0] pwdata,             // apb write data
    input wire logic [tcsp_pkg::DATA_W-1:0] prdata,             // apb read data
    input wire logic                        pready,             // apb ready
    input wire logic                        pslverr,            // apb error
    input wire logic                        irq_mask,           // global mask
    input wire logic                        compare_pin_one,    // compare out 1
    input wire logic                        compare_pin_two,    // compare out 2
    input wire logic                        compare_pin_en_one, // pin 1 owned
    input wire logic                        compare_pin_en_two, // pin 2 owned
    input wire logic                        timer_irq           // interrupt
);
    import tcsp_pkg::*;
    wire logic        done = psel && penable && pready;
    wire logic        wr_c1 = done && pwrite && paddr == OFS_CONTROL_ONE && pwdata[3];
    logic      [15:0] c1_q;
    logic      [15:0] c2_q;
    logic      [7:0]  k1_q;
    logic      [7:0]  k2_q;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            c1_q <= CMP_RESET_VALUE;
            c2_q <= CMP_RESET_VALUE;
            k1_q <= CONTROL_RESET;
            k2_q <= CONTROL_RESET;
        end
        else if (done && pwrite && !pslverr)
        begin
            if (paddr == OFS_CMP1_HIGH) c1_q[15:8] <= pwdata[7:0];
            if (paddr == OFS_CMP1_LOW) c1_q[7:0] <= pwdata[7:0];
            if (paddr == OFS_CMP2_HIGH) c2_q[15:8] <= pwdata[7:0];
            if (paddr == OFS_CMP2_LOW) c2_q[7:0] <= pwdata[7:0];
            if (paddr == OFS_CONTROL_ONE) k1_q <= pwdata[7:0];
            if (paddr == OFS_CONTROL_TWO) k2_q <= pwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_reset_low: assert property (disable iff (1'b0) !arst_n |-> !compare_pin_one && !compare_pin_two)
        else $error("compare pin high during reset");
    a_ready_wait: assert property (psel && !penable && ce |=> !pready)
        else $error("ready without wait state");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_cmp1_read: assert property (done && !pwrite && (paddr == OFS_CMP1_HIGH || paddr == OFS_CMP1_LOW)
        |-> prdata[7:0] == (paddr == OFS_CMP1_HIGH ? c1_q[15:8] : c1_q[7:0]))
        else $error("compare value one read wrong");
    a_cmp2_read: assert property (done && !pwrite && (paddr == OFS_CMP2_HIGH || paddr == OFS_CMP2_LOW)
        |-> prdata[7:0] == (paddr == OFS_CMP2_HIGH ? c2_q[15:8] : c2_q[7:0]))
        else $error("compare value two read wrong");
    a_pin_owner: assert property (compare_pin_en_one == k2_q[7] && compare_pin_en_two == k2_q[6])
        else $error("pin enable differs from control");
    a_force_copy: assert property (wr_c1 && k2_q[7] && !k2_q[4] && !k2_q[5]
        |=> ##[0:1] compare_pin_one == k1_q[0])
        else $error("forced level not on pin");
    a_force_none: assert property (wr_c1 && (k2_q[4] || k2_q[5]) |=> $stable(compare_pin_one) [*2])
        else $error("force acted in pulse mode");
    a_irq_masked: assert property (irq_mask && $past(irq_mask) |-> !timer_irq)
        else $error("interrupt while masked");
    cover property (done && pslverr);
    cover property ($rose(compare_pin_one));
    cover property ($rose(timer_irq));
endmodule // tcsp_timer_sva
bind tcsp_timer tcsp_timer_sva u_sva (.*);

// file: timer_compare_single_pulse_tb.sv
`timescale 1ns/1ps
module timer_compare_single_pulse_tb;
    import tcsp_pkg::*;
    logic        mclk, arst_n, psel, penable, pwrite, irq_mask, cap1, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, r;
    wire  [31:0] prdata;
    wire         pready, pslverr, p1, p2, e1, irq;
    int          fail_count = 0, n_tests = 0, cyc = 0, n;
    logic [15:0] c;
    tcsp_timer uut (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_mask(irq_mask), .ext_clk_pin(1'b0), .capture_pin_one(cap1),
        .capture_pin_two(1'b0), .compare_pin_one(p1), .compare_pin_two(p2),
        .compare_pin_en_one(e1), .compare_pin_en_two(), .timer_irq(irq));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // an idle edge between transfers keeps each driver to one assignment per step
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wt(input logic v, input int lim);
        n = 0;
        while (p1 !== v && n < lim)
        begin
            @(negedge mclk);
            n++;
        end
    endtask
    task get_cnt(input int ahead);
        do
        begin
            apb(0, OFS_COUNT_LOW, 8'h00); c[7:0] = r[7:0];
            apb(0, OFS_COUNT_HIGH, 8'h00); c[15:8] = r[7:0];
        end
        while (c[7:0] > 8'hF0);
        c = c + 16'(ahead);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        apb(0, OFS_CMP1_HIGH, 8'h00); chk("cmp1_high", r, 32'h80);
        apb(0, OFS_CMP1_LOW, 8'h00); chk("cmp1_low", r, 32'h00);
        apb(0, OFS_CMP2_HIGH, 8'h00); chk("cmp2_high", r, 32'h80);
        apb(0, 8'hFC, 8'h00); chk("unmapped_err", e, 1'b1);
        chk("unmapped_data", r, 32'h0);
        apb(1, OFS_CMP2_LOW, 8'h5A); apb(0, OFS_CMP2_LOW, 8'h00); chk("cmp2_low", r, 32'h5A);
    endtask
    task t_match;
        apb(1, OFS_CONTROL_TWO, 8'h80);
        apb(1, OFS_CONTROL_ONE, 8'h43);
        get_cnt(60);
        apb(1, OFS_CMP1_HIGH, c[15:8]); apb(0, OFS_STATUS, 8'h00); apb(1, OFS_CMP1_LOW, c[7:0]);
        wt(1'b1, 300); chk("match_pin", p1, 1'b1);
        apb(0, OFS_STATUS, 8'h00); chk("match_flag", r[0], 1'b1);
        chk("irq_masked", irq, 1'b0);
        irq_mask <= 1'b0;
        repeat (2) @(negedge mclk);
        chk("irq_on", irq, 1'b1);
        apb(0, OFS_CMP1_LOW, 8'h00); apb(0, OFS_STATUS, 8'h00); chk("flag_clear", r[0], 1'b0);
    endtask
    task t_cmp2(input logic inh);
        get_cnt(40);
        apb(1, OFS_CMP2_HIGH, c[15:8]); apb(1, OFS_CMP2_LOW, c[7:0]);
        if (inh) apb(1, OFS_CMP2_HIGH, c[15:8]);
        repeat (150) @(negedge mclk);
        apb(0, OFS_STATUS, 8'h00); chk("flag_two", r[1], !inh);
        chk("pin_two_idle", p2, 1'b0);
        chk("irq_two", irq, !inh);
        apb(0, OFS_CMP2_LOW, 8'h00);
    endtask
    task t_force;
        apb(1, OFS_CONTROL_ONE, 8'h48); wt(1'b0, 3); chk("force_low", p1, 1'b0);
        apb(1, OFS_CONTROL_ONE, 8'h49); wt(1'b1, 3); chk("force_high", p1, 1'b1);
        apb(0, OFS_STATUS, 8'h00); chk("force_noflag", r[0], 1'b0);
        chk("force_noirq", irq, 1'b0);
    endtask
    task t_pulse;
        apb(1, OFS_CMP1_HIGH, 8'h00); apb(1, OFS_CMP1_LOW, 8'h14);
        apb(1, OFS_CONTROL_TWO, 8'h90);
        apb(1, OFS_CONTROL_ONE, 8'h8C); repeat (3) @(negedge mclk); chk("spm_force", p1, 1'b1);
        apb(1, OFS_CONTROL_ONE, 8'h85);
        cap1 <= 1'b1;
        wt(1'b0, 20); chk("pulse_start", p1, 1'b0);
        wt(1'b1, 100); chk("pulse_end", p1, 1'b1);
        chk("pulse_len", n >= 46 && n <= 52, 1'b1);
        chk("pulse_irq", irq, 1'b1);
        apb(0, OFS_STATUS, 8'h00); chk("cap_flag", r[2], 1'b1);
        chk("no_flag_one", r[0], 1'b0);
        apb(0, OFS_CAP1_HIGH, 8'h00); chk("cap_high", r, 32'hFF);
        apb(0, OFS_CAP1_LOW, 8'h00); chk("cap_low", r, 32'hFD);
        apb(1, OFS_CONTROL_TWO, 8'hB0);
        cap1 <= 1'b0;
        repeat (6) @(posedge mclk);
        cap1 <= 1'b1;
        repeat (30) @(negedge mclk);
        chk("pwm_wins", p1, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            end_of_test;
        end
    end
    initial
    begin
        arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; irq_mask = 1'b1; cap1 = 1'b0;
        repeat (2) @(posedge mclk);
        chk("pin_reset", p1, 1'b0);
        arst_n <= 1'b1;
        t_reset;
        t_match;
        t_cmp2(1'b0);
        t_cmp2(1'b1);
        t_force;
        t_pulse;
        end_of_test;
    end
endmodule // timer_compare_single_pulse_tb
